/* File: cpo_pkg.sv */
// constants, bit positions and state encodings shared by the prom output control files
`default_nettype none
package cpo_pkg;
	// =========================================================================
	// clock and timing
	localparam int unsigned CLK_FREQ_MHZ  = 250;
	localparam int unsigned US_PER_MS     = 1000;
	localparam int unsigned T_OER_MAX_MS  = 1;
	localparam int unsigned T_RST_MIN_MS  = 10;
	// longest release delay rounds down, shortest brown-out time rounds up; both come out exact
	localparam int unsigned OER_CYCLES    = T_OER_MAX_MS * US_PER_MS * CLK_FREQ_MHZ;
	localparam int unsigned RST_CYCLES    = T_RST_MIN_MS * US_PER_MS * CLK_FREQ_MHZ;
	localparam int unsigned CLK_HALF_DIV  = 2;
	// clocks from a supply pin edge to the delay state: two sync stages and the hold state
	localparam int unsigned SYNC_LAT      = 3;

	// =========================================================================
	// array geometry and buffering
	localparam int unsigned ADDR_W        = 16;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned FIFO_DEPTH    = 32;
	localparam int unsigned RESET_ADDR    = 0;

	// =========================================================================
	// synchroniser bit positions and reset levels
	localparam int unsigned SYN_CFG       = 0;
	localparam int unsigned SYN_CE        = 1;
	localparam int unsigned SYN_OE        = 2;
	localparam int unsigned SYN_BUSY      = 3;
	localparam int unsigned SYN_PWR       = 4;
	localparam int unsigned SYN_W         = 5;
	// chip enable resets to deasserted so the block wakes in standby
	localparam logic [SYN_W-1:0] SYN_RESET = 5'h02;

	// =========================================================================
	// supply sequencing states
	typedef enum logic [1:0] {
		PWR_HOLD  = 2'b00,
		PWR_DELAY = 2'b01,
		PWR_RUN   = 2'b10
	} cpo_pwr_e;
endpackage : cpo_pkg
`default_nettype wire

/* File: cpo_sync.sv */
// two-flop level synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module cpo_sync #(
	parameter int unsigned       WIDTH     = 1,
	parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	// =========================================================================
	// stages
	logic [WIDTH-1:0] meta_q;

	// the first stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q  <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : cpo_sync
`default_nettype wire

/* File: cpo_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/1ns
`default_nettype none
module cpo_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             flush,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// =========================================================================
	// storage and pointers
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	wire              push   = inValid && inReady;
	wire              pop    = outValid && outReady;
	wire  [AW-1:0]    wrNext = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
	wire  [AW-1:0]    rdNext = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;

	assign inReady  = (count_q != (AW + 1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem_q[rdPtr_q];

	// =========================================================================
	// write port; entries need no reset since count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wrPtr_q <= wrNext;
			if (pop) rdPtr_q <= rdNext;
			if (push && !pop) count_q <= count_q + 1'b1;
			else if (pop && !push) count_q <= count_q - 1'b1;
		end
	end
endmodule : cpo_fifo
`default_nettype wire

/* File: cpo_output_control.sv */
// output, address and reset-pin control of a configuration prom facing the fpga port
`timescale 1ns/1ns
`default_nettype none
module cpo_output_control #(
	parameter int unsigned ADDR_W           = cpo_pkg::ADDR_W,
	parameter int unsigned DATA_W           = cpo_pkg::DATA_W,
	parameter int unsigned FIFO_DEPTH       = cpo_pkg::FIFO_DEPTH,
	parameter bit          PARALLEL_VARIANT = 1'b1,
	parameter int unsigned CLK_HALF_DIV     = cpo_pkg::CLK_HALF_DIV,
	parameter int unsigned RELEASE_CYCLES   = cpo_pkg::OER_CYCLES,
	parameter int unsigned TRST_CYCLES      = cpo_pkg::RST_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              cfgClk,
	input  wire logic              chipEnableN,
	input  wire logic              busy,
	input  wire logic              powerGood,
	input  wire logic              resetPinIn,
	output var  logic              resetPinOut,
	output var  logic              resetPinOeN,
	input  wire logic              revBankEnable,
	input  wire logic [ADDR_W-1:0] revStartAddr,
	input  wire logic [ADDR_W-1:0] revEndAddr,
	output var  logic              arrayReadReq,
	output var  logic [ADDR_W-1:0] arrayReadAddr,
	input  wire logic [DATA_W-1:0] arrayReadData,
	output var  logic [DATA_W-1:0] dataOut,
	output var  logic              dataOeN,
	output var  logic              cascade_enable_out_n,
	output var  logic              derived_clock_out,
	output var  logic              derivedClockOeN,
	output var  logic              standbyMode,
	output var  logic              reducedCurrent,
	output var  logic [ADDR_W-1:0] currentAddr
);
	localparam logic [ADDR_W-1:0] terminal_count = {ADDR_W{1'b1}};
	localparam logic [ADDR_W-1:0] ZERO_ADDR      = ADDR_W'(cpo_pkg::RESET_ADDR);
	localparam logic [7:0]        DIV_LAST       = 8'(CLK_HALF_DIV - 1);
	// the pin synchroniser and the hold state eat part of the release window,
	// so the delay counter stops that much sooner to keep the pin inside its limit
	localparam int unsigned       DELAY_CYCLES   = (RELEASE_CYCLES > cpo_pkg::SYNC_LAT) ?
		RELEASE_CYCLES - cpo_pkg::SYNC_LAT : 32'h1;

	// =========================================================================
	// pin synchronisers
	logic [cpo_pkg::SYN_W-1:0] syncIn;
	logic [cpo_pkg::SYN_W-1:0] syncOut;
	logic                      cfgPrev_q;

	assign syncIn[cpo_pkg::SYN_CFG]  = cfgClk;
	assign syncIn[cpo_pkg::SYN_CE]   = chipEnableN;
	assign syncIn[cpo_pkg::SYN_OE]   = resetPinIn;
	assign syncIn[cpo_pkg::SYN_BUSY] = busy;
	assign syncIn[cpo_pkg::SYN_PWR]  = powerGood;

	cpo_sync #(
		.WIDTH     (cpo_pkg::SYN_W),
		.RESET_VAL (cpo_pkg::SYN_RESET)
	) u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.asyncIn (syncIn),
		.syncOut (syncOut)
	);

	wire cfgLevel  = syncOut[cpo_pkg::SYN_CFG];
	wire ceHigh    = syncOut[cpo_pkg::SYN_CE];
	wire oeLevel   = syncOut[cpo_pkg::SYN_OE];
	wire busyLevel = syncOut[cpo_pkg::SYN_BUSY];
	wire pwrGood   = syncOut[cpo_pkg::SYN_PWR];
	// edge found in the same cycle the second stage goes high; cfgClk must stay well below clk/4
	wire cfgRise   = cfgLevel && !cfgPrev_q;

	// =========================================================================
	// supply sequencing
	// one counter serves the release delay and the brown-out timer
	cpo_pkg::cpo_pwr_e pwrState_q;
	cpo_pkg::cpo_pwr_e pwrState_d;
	logic [31:0]       pwrCnt_q;
	logic [31:0]       pwrCnt_d;

	always_comb begin
		pwrState_d = pwrState_q;
		pwrCnt_d   = pwrCnt_q;
		case (pwrState_q)
			cpo_pkg::PWR_HOLD: begin
				pwrCnt_d = '0;
				if (pwrGood) pwrState_d = cpo_pkg::PWR_DELAY;
			end
			cpo_pkg::PWR_DELAY: begin
				// a dip during the delay restarts it from the hold state
				if (!pwrGood) begin
					pwrState_d = cpo_pkg::PWR_HOLD;
					pwrCnt_d   = '0;
				end else if (pwrCnt_q >= DELAY_CYCLES - 32'h1) begin
					pwrState_d = cpo_pkg::PWR_RUN;
					pwrCnt_d   = '0;
				end else begin
					pwrCnt_d = pwrCnt_q + 32'h1;
				end
			end
			cpo_pkg::PWR_RUN: begin
				// short dips are ridden through; only a sustained low restarts
				if (pwrGood) begin
					pwrCnt_d = '0;
				end else if (pwrCnt_q >= TRST_CYCLES - 32'h1) begin
					pwrState_d = cpo_pkg::PWR_HOLD;
					pwrCnt_d   = '0;
				end else begin
					pwrCnt_d = pwrCnt_q + 32'h1;
				end
			end
			default: begin
				pwrState_d = cpo_pkg::PWR_HOLD;
				pwrCnt_d   = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwrState_q <= cpo_pkg::PWR_HOLD;
			pwrCnt_q   <= '0;
		end else begin
			pwrState_q <= pwrState_d;
			pwrCnt_q   <= pwrCnt_d;
		end
	end

	wire pwrHold = (pwrState_q != cpo_pkg::PWR_RUN);

	// open-drain: only ever pulls low, the external pull-up releases it
	assign resetPinOut = 1'b0;
	assign resetPinOeN = !pwrHold;

	// =========================================================================
	// mode decode
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] fetchAddr_q;
	logic [DATA_W-1:0] dataOut_q;
	logic              primed_q;
	logic              fetchPend_q;
	logic              fifoInReady;
	logic              fifoOutValid;
	logic [DATA_W-1:0] fifoOutData;

	// bank addresses are used live; change them only while held in reset or standby
	wire               revOn      = PARALLEL_VARIANT && revBankEnable;
	wire [ADDR_W-1:0]  startAddr  = revOn ? revStartAddr : ZERO_ADDR;
	wire [ADDR_W-1:0]  stopAddr   = revOn ? revEndAddr : terminal_count;
	wire               inStandby  = ceHigh;
	wire               pinReset   = !oeLevel;
	wire               enabled    = !inStandby && !pinReset && !pwrHold;
	wire               atTerm     = (addr_q == terminal_count);
	// a stop at or below the current address halts at once and never wraps
	wire               belowStop  = (addr_q < stopAddr);
	wire               running    = enabled && primed_q && belowStop;
	wire               busyHold   = PARALLEL_VARIANT && busyLevel && running;
	wire [ADDR_W-1:0]  addrNext   = addr_q + 1'b1;
	wire               lastStep   = (addrNext == stopAddr);

	// =========================================================================
	// stepping on configuration clock edges
	logic stepPend_q;

	wire stepEdge  = cfgRise && running && !busyHold;
	// an edge with the next word not yet buffered is held off until it arrives,
	// so a slow array costs latency but never a lost word
	wire stepReq   = (stepEdge || stepPend_q) && running && !busyHold;
	wire stepGo    = stepReq && (lastStep || fifoOutValid);
	wire stepPop   = stepReq && !lastStep && fifoOutValid;
	// a held edge survives busy; only reset, standby or the stop drop it
	wire stepHold  = (stepEdge || stepPend_q) && !stepGo;
	wire primeLoad = enabled && !primed_q && belowStop && fifoOutValid;
	wire fifoPop   = primeLoad || stepPop;
	wire flush     = !enabled;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stepPend_q <= 1'b0;
		end else if (flush) begin
			stepPend_q <= 1'b0;
		end else begin
			stepPend_q <= stepHold && running;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfgPrev_q <= 1'b0;
		end else begin
			cfgPrev_q <= cfgLevel;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q   <= ZERO_ADDR;
			primed_q <= 1'b0;
		end else if (flush) begin
			addr_q   <= startAddr;
			primed_q <= 1'b0;
		end else begin
			if (primeLoad) primed_q <= 1'b1;
			if (stepGo) addr_q <= addrNext;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dataOut_q <= '0;
		end else if (fifoPop) begin
			dataOut_q <= fifoOutData;
		end
	end

	// =========================================================================
	// array prefetch into the buffer
	// one read in flight at a time, so space checked at issue is still there on return
	wire fetchIssue = enabled && !fetchPend_q && (fetchAddr_q < stopAddr) && fifoInReady;
	// a word still in flight when the frame ends is discarded, not kept for the next
	wire fetchPush  = enabled && fetchPend_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetchAddr_q <= ZERO_ADDR;
			fetchPend_q <= 1'b0;
		end else if (flush) begin
			fetchAddr_q <= startAddr;
			fetchPend_q <= 1'b0;
		end else begin
			fetchPend_q <= fetchIssue;
			if (fetchIssue) fetchAddr_q <= fetchAddr_q + 1'b1;
		end
	end

	assign arrayReadReq  = fetchIssue;
	assign arrayReadAddr = fetchAddr_q;

	// the flush empties the buffer so a new frame never sees stale words
	cpo_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.resetn   (resetn),
		.flush    (flush),
		.inValid  (fetchPush),
		.inReady  (fifoInReady),
		.inData   (arrayReadData),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData)
	);

	// =========================================================================
	// derived clock divider
	// runs free and only its enable follows the mode, so the first pulse may be short
	logic [7:0] divCnt_q;
	logic       divClk_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			divCnt_q <= '0;
			divClk_q <= 1'b0;
		end else if (divCnt_q >= DIV_LAST) begin
			divCnt_q <= '0;
			divClk_q <= !divClk_q;
		end else begin
			divCnt_q <= divCnt_q + 8'h01;
		end
	end

	// =========================================================================
	// outputs
	// enables are decoded from state, so they move in the same cycle as the mode
	assign dataOut              = dataOut_q;
	assign dataOeN              = !running;
	assign cascade_enable_out_n = !(enabled && atTerm);
	assign derived_clock_out    = divClk_q;
	assign derivedClockOeN      = !(PARALLEL_VARIANT && running);
	assign standbyMode          = inStandby;
	assign reducedCurrent       = enabled && !belowStop;
	assign currentAddr          = addr_q;
endmodule : cpo_output_control
`default_nettype wire

/* File: cpo_output_control_props.sv */
// concurrent checks on the prom output control ports
`timescale 1ns/1ns
`default_nettype none
module cpo_output_control_props #(
	parameter int unsigned ADDR_W         = 16,
	parameter int unsigned DATA_W         = 8,
	parameter int unsigned RELEASE_CYCLES = 20,
	parameter int unsigned TRST_CYCLES    = 40
) (
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              powerGood,
	input wire logic              resetPinOut,
	input wire logic              resetPinOeN,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic              dataOeN,
	input wire logic              cascade_enable_out_n,
	input wire logic              derivedClockOeN,
	input wire logic              standbyMode,
	input wire logic              reducedCurrent,
	input wire logic [ADDR_W-1:0] currentAddr
);
	// ====
	int unsigned lowCnt_q;
	int unsigned pgLowCnt_q;
	int unsigned pgHighCnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// counts the raw pin, so sync latency only lengthens what the design sees
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowCnt_q <= 0;
			pgLowCnt_q <= 0;
			pgHighCnt_q <= 0;
		end else begin
			lowCnt_q <= resetPinOeN ? 0 : lowCnt_q + 1;
			pgLowCnt_q <= powerGood ? 0 : pgLowCnt_q + 1;
			pgHighCnt_q <= (powerGood && !resetPinOeN) ? pgHighCnt_q + 1 : 0;
		end
	end
	sequence s_heldStandby;
		standbyMode [*3];
	endsequence
	sequence s_stepped;
		!dataOeN && !$past(dataOeN) && currentAddr != $past(currentAddr);
	endsequence
	property p_pin; resetPinOut == 1'b0; endproperty
	property p_release; $rose(resetPinOeN) |-> lowCnt_q >= RELEASE_CYCLES; endproperty
	property p_brown; $fell(resetPinOeN) |-> pgLowCnt_q >= TRST_CYCLES; endproperty
	property p_standby;
		s_heldStandby |-> dataOeN && derivedClockOeN && cascade_enable_out_n;
	endproperty
	property p_cascade;
		!cascade_enable_out_n |-> currentAddr == {ADDR_W{1'b1}} && reducedCurrent;
	endproperty
	property p_stop; reducedCurrent |-> dataOeN && derivedClockOeN; endproperty
	property p_step; s_stepped |-> currentAddr == $past(currentAddr) + 1'b1; endproperty
	property p_hold;
		!dataOeN && !$past(dataOeN) && $stable(currentAddr) |-> $stable(dataOut);
	endproperty
	property p_active; !dataOeN |-> !standbyMode && resetPinOeN; endproperty
	property p_releaseBound; pgHighCnt_q <= RELEASE_CYCLES; endproperty
	a_pin: assert property (p_pin) else $error("reset pin drive value not low");
	a_release: assert property (p_release) else $error("reset pin released early");
	a_brown: assert property (p_brown) else $error("reset on short supply dip");
	a_standby: assert property (p_standby) else $error("outputs driven in standby");
	a_cascade: assert property (p_cascade) else $error("cascade low off top");
	a_stop: assert property (p_stop) else $error("outputs driven at stop");
	a_step: assert property (p_step) else $error("address step not one");
	a_hold: assert property (p_hold) else $error("data changed without step");
	a_active: assert property (p_active) else $error("data driven in reset");
	a_releaseBound: assert property (p_releaseBound) else $error("reset pin held too long");
endmodule : cpo_output_control_props
bind cpo_output_control cpo_output_control_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
	.RELEASE_CYCLES(RELEASE_CYCLES), .TRST_CYCLES(TRST_CYCLES)) u_props (.clk, .resetn,
	.powerGood, .resetPinOut, .resetPinOeN, .dataOut, .dataOeN, .cascade_enable_out_n,
	.derivedClockOeN, .standbyMode, .reducedCurrent, .currentAddr);
`default_nettype wire

/* File: cpo_fpga_model.sv */
// far side model: configuration clock source and array read port
`timescale 1ns/1ns
`default_nettype none
module cpo_fpga_model (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        go,
	output var  logic        cfgClk,
	input  wire logic        arrayReadReq,
	input  wire logic [15:0] arrayReadAddr,
	output var  logic [7:0]  arrayReadData
);
	// ====
	logic [2:0] phase_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 3'h0;
			cfgClk <= 1'b0;
			arrayReadData <= 8'h00;
		end else begin
			// clock stands still between frames so standby current stays low
			if (go) phase_q <= phase_q + 3'h1;
			if (go && phase_q == 3'h7) cfgClk <= ~cfgClk;
			// word valid only the cycle after the request, noise otherwise
			arrayReadData <= arrayReadReq ?
				(arrayReadAddr[7:0] ^ arrayReadAddr[15:8] ^ 8'h5A) : ~arrayReadData;
		end
	end
endmodule : cpo_fpga_model
`default_nettype wire

/* File: cpo_output_control_bench.sv */
// self-checking bench of the prom output control block
`timescale 1ns/1ns
`default_nettype none
module cpo_output_control_bench;
	// ====
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        go = 1'b0;
	logic        chipEnableN = 1'b1;
	logic        busy = 1'b0;
	logic        powerGood = 1'b0;
	logic        oeDrv = 1'b1;
	logic        revBankEnable = 1'b0;
	logic [15:0] revStartAddr = 16'h0000;
	logic [15:0] revEndAddr = 16'h0000;
	logic        cfgClk, resetWire, resetPinOut, resetPinOeN, arrayReadReq;
	logic [15:0] arrayReadAddr, currentAddr, s;
	logic [7:0]  arrayReadData, dataOut;
	logic        dataOeN, cascadeN, derivedClk, derivedClockOeN, standbyMode, reducedCurrent;
	logic        arrayReadReqSer, dataOeNSer, derivedClockOeNSer, lastClk;
	logic [15:0] arrayReadAddrSer, currentAddrSer;
	logic [7:0]  arrayReadDataSer, dataOutSer;
	int          bad_count = 0;
	int          checks = 0;
	int          edges = 0;
	int          cyc = 0;
	int          n;
	// open-drain wire with pull-up, the bench acting as the other puller
	assign resetWire = resetPinOeN ? oeDrv : resetPinOut;
	always #2 clk = ~clk;
	always @(posedge cfgClk) edges++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	cpo_output_control #(.RELEASE_CYCLES(20), .TRST_CYCLES(40)) dut (.clk(clk), .resetn(resetn),
		.cfgClk(cfgClk), .chipEnableN(chipEnableN), .busy(busy), .powerGood(powerGood),
		.resetPinIn(resetWire), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
		.revBankEnable(revBankEnable), .revStartAddr(revStartAddr), .revEndAddr(revEndAddr),
		.arrayReadReq(arrayReadReq), .arrayReadAddr(arrayReadAddr),
		.arrayReadData(arrayReadData), .dataOut(dataOut), .dataOeN(dataOeN),
		.cascade_enable_out_n(cascadeN), .derived_clock_out(derivedClk),
		.derivedClockOeN(derivedClockOeN), .standbyMode(standbyMode),
		.reducedCurrent(reducedCurrent), .currentAddr(currentAddr));
	cpo_fpga_model u_fpga (.clk(clk), .resetn(resetn), .go(go), .cfgClk(cfgClk),
		.arrayReadReq(arrayReadReq), .arrayReadAddr(arrayReadAddr),
		.arrayReadData(arrayReadData));
	// serial variant on the same pins: ignores busy and banking, never drives a clock
	cpo_output_control #(.PARALLEL_VARIANT(1'b0), .RELEASE_CYCLES(20), .TRST_CYCLES(40))
		dutSer (.clk(clk), .resetn(resetn), .cfgClk(cfgClk), .chipEnableN(chipEnableN),
		.busy(busy), .powerGood(powerGood), .resetPinIn(resetWire), .resetPinOut(),
		.resetPinOeN(), .revBankEnable(revBankEnable), .revStartAddr(revStartAddr),
		.revEndAddr(revEndAddr), .arrayReadReq(arrayReadReqSer),
		.arrayReadAddr(arrayReadAddrSer), .arrayReadData(arrayReadDataSer),
		.dataOut(dataOutSer), .dataOeN(dataOeNSer), .cascade_enable_out_n(),
		.derived_clock_out(), .derivedClockOeN(derivedClockOeNSer), .standbyMode(),
		.reducedCurrent(), .currentAddr(currentAddrSer));
	cpo_fpga_model u_fpgaSer (.clk(clk), .resetn(resetn), .go(go), .cfgClk(),
		.arrayReadReq(arrayReadReqSer), .arrayReadAddr(arrayReadAddrSer),
		.arrayReadData(arrayReadDataSer));
	function automatic logic [7:0] word(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5A;
	endfunction : word
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// lets k configuration clock edges through, then parks the clock
	task automatic run(input int k);
		int t;
		t = edges + k;
		@(posedge clk) go <= 1'b1;
		while (edges < t) @(posedge clk);
		go <= 1'b0;
		tick(12);
	endtask : run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	initial begin
		void'($urandom(32'h4bf2));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		tick(1);
		chk(resetPinOeN, 0);
		chk(dataOeN, 1);
		chk(cascadeN, 1);
		@(posedge clk) powerGood <= 1'b1;
		tick(10);
		chk(resetPinOeN, 0);
		tick(20);
		chk(resetPinOeN, 1);
		@(posedge clk) chipEnableN <= 1'b0;
		tick(10);
		chk(dataOeN, 0);
		chk(dataOut, word(16'h0000));
		chk(derivedClockOeN, 0);
		chk(dataOeNSer, 0);
		chk(dataOutSer, word(16'h0000));
		chk(derivedClockOeNSer, 1);
		lastClk = derivedClk;
		tick(cpo_pkg::CLK_HALF_DIV);
		chk(derivedClk, !lastClk);
		n = $urandom_range(3, 9);
		run(n);
		chk(currentAddr, 16'(n));
		chk(dataOut, word(16'(n)));
		chk(currentAddrSer, 16'(n));
		chk(dataOutSer, word(16'(n)));
		@(posedge clk) busy <= 1'b1;
		tick(4);
		run(3);
		chk(currentAddr, 16'(n));
		chk(dataOut, word(16'(n)));
		chk(derivedClockOeN, 0);
		chk(currentAddrSer, 16'(n) + 16'h3);
		chk(dataOutSer, word(16'(n) + 16'h3));
		@(posedge clk) busy <= 1'b0;
		// first a random bank, then one whose end address is the top address
		for (int i = 0; i < 2; i++) begin
			s = i ? 16'hFFFC : 16'($urandom_range(256, 61440));
			@(posedge clk);
			revBankEnable <= 1'b1;
			revStartAddr <= s;
			revEndAddr <= s + 16'h3;
			oeDrv <= 1'b0;
			tick(6);
			chk(currentAddr, s);
			chk(derivedClockOeN, 1);
			chk(dataOeN, 1);
			chk(currentAddrSer, 16'h0000);
			chk(dataOeNSer, 1);
			@(posedge clk) oeDrv <= 1'b1;
			tick(10);
			chk(dataOut, word(s));
			run(5);
			chk(currentAddr, s + 16'h3);
			chk(dataOeN, 1);
			chk(derivedClockOeN, 1);
			chk(reducedCurrent, 1);
			chk(cascadeN, i ? 16'h0 : 16'h1);
			chk(currentAddrSer, 16'h0005);
			chk(dataOutSer, word(16'h0005));
			chk(dataOeNSer, 0);
		end
		@(posedge clk) chipEnableN <= 1'b1;
		tick(6);
		chk(standbyMode, 1);
		chk(currentAddr, 16'hFFFC);
		chk(cascadeN, 1);
		chk(dataOeN, 1);
		chk(currentAddrSer, 16'h0000);
		chk(dataOeNSer, 1);
		@(posedge clk) powerGood <= 1'b0;
		tick(20);
		@(posedge clk) powerGood <= 1'b1;
		tick(30);
		chk(resetPinOeN, 1);
		@(posedge clk) powerGood <= 1'b0;
		tick(50);
		chk(resetPinOeN, 0);
		@(posedge clk) powerGood <= 1'b1;
		tick(30);
		chk(resetPinOeN, 1);
		give_verdict();
	end
endmodule : cpo_output_control_bench
`default_nettype wire
